// ===== rtl/tx_baud_pkg.sv
// Purpose: Shared constants for the transmit holding and baud generator block
// Assumes: Registers reached over a plain strobe port, 32-bit words
// Notes:   Offsets are byte addresses
package tx_baud_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] TX_HOLDING_ADDR  = 32'h4002401c;
  localparam logic [31:0] BAUD_GEN_ADDR    = 32'h40024020;
  localparam logic [31:0] MODE_CTRL_ADDR   = 32'h40024004;
  localparam logic [31:0] WR_PROT_ADDR     = 32'h400240e4;
  localparam logic [31:0] STATUS_ADDR      = 32'h40024014;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHAR_MSB      = 8;
  localparam int SYNC_BIT      = 15;
  localparam int CD_MSB        = 15;
  localparam int FP_LSB        = 16;
  localparam int FP_MSB        = 18;
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB      = 1;
  localparam int OVER_BIT      = 2;
  localparam int RATIO_LSB     = 16;
  localparam int RATIO_MSB     = 26;
  localparam int WRITE_PROTECT_ENABLE_BIT      = 0;
  localparam int TX_HOLDING_READY_BIT     = 1;
  // ----------------------------------------------------------------
  // Reset values and factors
  // ----------------------------------------------------------------
  localparam logic [15:0] CD_RESET    = 16'h0000;
  localparam logic [2:0]  FP_RESET    = 3'h0;
  localparam logic [10:0] RATIO_RESET = 11'h174;
  localparam logic [4:0]  OVS_16      = 5'h10;
  localparam logic [4:0]  OVS_8       = 5'h08;
  localparam logic [4:0]  OVS_1       = 5'h01;
  localparam int          FRAC_STEPS  = 8;
  typedef enum logic [1:0] {MODE_ASYNC, MODE_SYNC, MODE_SPI, MODE_ISO} usart_mode_type;
endpackage

// ===== rtl/tx_hold_buf.sv
// Purpose: Two-entry valid/ready buffer for transmit characters
// Assumes: Same clock as the register port
// Notes:   Full ready only from stored state, no combinational path in to out
`timescale 1ns/1ps
module tx_hold_buf (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Fill side
  input  wire logic        in_valid_in,
  output logic             in_ready_out,
  input  wire logic [9:0]  in_data_in,
  // Drain side
  output logic             out_valid_out,
  input  wire logic        out_ready_in,
  output logic [9:0]       out_data_out
);
  logic [9:0] mem_reg [2];
  logic [9:0] mem_next [2];
  logic       rd_ptr_reg, rd_ptr_next, wr_ptr_reg, wr_ptr_next;
  logic [1:0] count_reg, count_next;
  logic       push, pop;

  assign in_ready_out  = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data_in;
      wr_ptr_next          = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mem_reg[0] <= 10'h000;
      mem_reg[1] <= 10'h000;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      mem_reg    <= mem_next;
      rd_ptr_reg <= rd_ptr_next;
      wr_ptr_reg <= wr_ptr_next;
      count_reg  <= count_next;
    end
  end
endmodule

// ===== rtl/usart_tx_holding_baud_gen.sv
// Purpose: Transmit holding register and baud rate generator
// Assumes: Shifter takes characters over valid/ready, one clock domain
// Notes:   Fractional step stretches some baud periods by one clock
// Function
// - Written 9-bit character goes out next when holding is ready
// - Sync bit 0 marks data delimiter, 1 marks command delimiter
// - Baud register writes ignored while write protection is enabled
// - Async baud is clock over 16 or 8 times divider; zero disables
// - Sync and SPI baud is clock over divider alone
// - Fractional field 0 disables, 1 to 7 adds that many eighths of a clock to the baud period
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module usart_tx_holding_baud_gen
  import tx_baud_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Register port
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  // Character stream to the shifter
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic [8:0]       tx_char_value_out,
  output logic             tx_sync_as_command_out,
  // Status and baud
  output logic             tx_holding_ready_out,
  output logic             baud_tick_out
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]    clock_divider_reg, clock_divider_next;
  logic [2:0]     fractional_part_reg, fractional_part_next;
  usart_mode_type mode_reg, mode_next;
  logic           over_reg, over_next;
  logic [10:0]    iso_rate_ratio_reg, iso_rate_ratio_next;
  logic           write_protect_enable_reg, write_protect_enable_next;
  logic [31:0]    rdata_reg, rdata_next;
  logic           buf_in_ready;
  logic [9:0]     buf_out;
  logic           hold_wr;

  // Holding write pushes only when there is room; a write while not ready is dropped
  assign hold_wr = wr_in && (addr_in == TX_HOLDING_ADDR);
  assign tx_holding_ready_out = buf_in_ready;

  always_comb begin
    clock_divider_next        = clock_divider_reg;
    fractional_part_next      = fractional_part_reg;
    mode_next                 = mode_reg;
    over_next                 = over_reg;
    iso_rate_ratio_next       = iso_rate_ratio_reg;
    write_protect_enable_next = write_protect_enable_reg;
    rdata_next                = 32'h0000_0000;
    if (wr_in) begin
      case (addr_in)
        BAUD_GEN_ADDR: begin
          if (!write_protect_enable_reg) begin
            clock_divider_next   = wdata_in[CD_MSB:0];
            fractional_part_next = wdata_in[FP_MSB:FP_LSB];
          end
        end
        MODE_CTRL_ADDR: begin
          mode_next           = usart_mode_type'(wdata_in[MODE_MSB:MODE_LSB]);
          over_next           = wdata_in[OVER_BIT];
          iso_rate_ratio_next = wdata_in[RATIO_MSB:RATIO_LSB];
        end
        WR_PROT_ADDR: write_protect_enable_next = wdata_in[WRITE_PROTECT_ENABLE_BIT];
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        BAUD_GEN_ADDR: begin
          rdata_next[CD_MSB:0]      = clock_divider_reg;
          rdata_next[FP_MSB:FP_LSB] = fractional_part_reg;
        end
        MODE_CTRL_ADDR: begin
          rdata_next[MODE_MSB:MODE_LSB]   = mode_reg;
          rdata_next[OVER_BIT]            = over_reg;
          rdata_next[RATIO_MSB:RATIO_LSB] = iso_rate_ratio_reg;
        end
        WR_PROT_ADDR: rdata_next[WRITE_PROTECT_ENABLE_BIT] = write_protect_enable_reg;
        STATUS_ADDR:  rdata_next[TX_HOLDING_READY_BIT] = buf_in_ready;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      clock_divider_reg        <= CD_RESET;
      fractional_part_reg      <= FP_RESET;
      mode_reg                 <= MODE_ASYNC;
      over_reg                 <= 1'b0;
      iso_rate_ratio_reg       <= RATIO_RESET;
      write_protect_enable_reg <= 1'b0;
      rdata_reg                <= 32'h0000_0000;
    end else begin
      clock_divider_reg        <= clock_divider_next;
      fractional_part_reg      <= fractional_part_next;
      mode_reg                 <= mode_next;
      over_reg                 <= over_next;
      iso_rate_ratio_reg       <= iso_rate_ratio_next;
      write_protect_enable_reg <= write_protect_enable_next;
      rdata_reg                <= rdata_next;
    end
  end
  assign rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // Holding buffer
  // ----------------------------------------------------------------
  // Queue next character
  tx_hold_buf u_hold (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (hold_wr),
    .in_ready_out  (buf_in_ready),
    .in_data_in    ({wdata_in[SYNC_BIT], wdata_in[CHAR_MSB:0]}),
    .out_valid_out (tx_valid_out),
    .out_ready_in  (tx_ready_in),
    .out_data_out  (buf_out)
  );
  assign tx_sync_as_command_out = buf_out[9];
  assign tx_char_value_out      = buf_out[8:0];

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  logic [4:0]  ovs;
  logic [26:0] period;
  logic [26:0] cnt_reg, cnt_next;
  logic [2:0]  frac_acc_reg, frac_acc_next;
  logic        tick_reg, tick_next;
  logic [3:0]  frac_sum;

  always_comb begin
    ovs = over_reg ? OVS_8 : OVS_16;
    if (mode_reg == MODE_SYNC || mode_reg == MODE_SPI) begin
      period = {11'h000, clock_divider_reg};
    end else if (mode_reg == MODE_ISO) begin
      // Operands widened first so the product is not cut to 16 bits
      period = 27'(clock_divider_reg) * 27'(iso_rate_ratio_reg);
    end else begin
      period = 27'(clock_divider_reg) * 27'(ovs);
    end
  end

  always_comb begin
    cnt_next      = cnt_reg;
    frac_acc_next = frac_acc_reg;
    tick_next     = 1'b0;
    frac_sum      = {1'b0, frac_acc_reg} + {1'b0, fractional_part_reg};
    if (clock_divider_reg == CD_RESET) begin
      cnt_next      = 27'h0;
      frac_acc_next = 3'h0;
    end else if (cnt_reg + 27'h1 >= period + 27'(frac_sum[3])) begin
      cnt_next      = 27'h0;
      frac_acc_next = frac_sum[2:0];
      tick_next     = 1'b1;
    end else begin
      cnt_next = cnt_reg + 27'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_reg      <= 27'h0;
      frac_acc_reg <= 3'h0;
      tick_reg     <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      frac_acc_reg <= frac_acc_next;
      tick_reg     <= tick_next;
    end
  end
  assign baud_tick_out = tick_reg;
endmodule

// ===== testbench/shifter_model.sv
// Purpose: Shifter taking characters from the holding buffer
// Assumes: One character per cycle unless stalled
// Notes:   Ready is registered, so a stall bites one cycle late
`timescale 1ns/1ps
module shifter_model (
  // Clock, reset and stall
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       stall_in,
  // Character stream
  input  wire logic       valid_in,
  input  wire logic [8:0] char_in,
  input  wire logic       sync_in,
  output logic            ready_out
);
  logic [9:0] got_q[$];
  always @(posedge clk_in) begin
    ready_out <= !srst_in && !stall_in;
    if (!srst_in && valid_in && ready_out) got_q.push_back({sync_in, char_in});
  end
endmodule

// ===== testbench/test_usart_tx_holding_baud_gen.sv
// Purpose: Self-checking bench for the holding and baud block
// Assumes: Shifter model stalls on request
// Notes:   Short dividers keep the run brief
`timescale 1ns/1ps
module test_usart_tx_holding_baud_gen;
  import tx_baud_pkg::*;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [31:0] addr_in = 32'h0;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        stall = 1'b1;
  logic [31:0] rdata_out;
  logic [8:0]  chr;
  logic        vld, rdy, syn, hrdy, tick;
  int          bad_count = 0;
  int          total_checks = 0;
  always #50 clk_in = ~clk_in;
  usart_tx_holding_baud_gen usart_tx_holding_baud_gen_i (.clk_in(clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .tx_valid_out(vld), .tx_ready_in(rdy), .tx_char_value_out(chr),
    .tx_sync_as_command_out(syn), .tx_holding_ready_out(hrdy), .baud_tick_out(tick));
  shifter_model shifter_model_i (.clk_in(clk_in), .srst_in(srst_in), .stall_in(stall),
    .valid_in(vld), .char_in(chr), .sync_in(syn), .ready_out(rdy));
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string name);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 check(name, rdata_out, exp);
  endtask
  task automatic t_prot();
    rd(BAUD_GEN_ADDR, 32'h0, "baud reset");
    rd(32'h40024100, 32'h0, "unmapped");
    wr(BAUD_GEN_ADDR, 32'h0005_0005);
    wr(WR_PROT_ADDR, 32'h1);
    wr(BAUD_GEN_ADDR, 32'h0000_0009);
    rd(BAUD_GEN_ADDR, 32'h0005_0005, "baud locked");
    wr(WR_PROT_ADDR, 32'h0);
    wr(BAUD_GEN_ADDR, 32'h0000_0009);
    rd(BAUD_GEN_ADDR, 32'h0000_0009, "baud open");
  endtask
  // Shifter stalled: two words fit, the third is dropped
  task automatic t_hold();
    rd(STATUS_ADDR, 32'h2, "status empty");
    check("ready pin empty", 32'(hrdy), 32'h1);
    wr(TX_HOLDING_ADDR, 32'h0000_01a5);
    wr(TX_HOLDING_ADDR, 32'h0000_805a);
    wr(TX_HOLDING_ADDR, 32'h0000_0033);
    rd(STATUS_ADDR, 32'h0, "status full");
    check("ready pin full", 32'(hrdy), 32'h0);
    rd(TX_HOLDING_ADDR, 32'h0, "holding read");
    stall <= 1'b0;
    for (int i = 0; i < 20; i++) @(posedge clk_in);
    check("word count", 32'(shifter_model_i.got_q.size()), 32'h2);
    check("data word", 32'(shifter_model_i.got_q[0]), 32'h1a5);
    check("command word", 32'(shifter_model_i.got_q[1]), 32'h25a);
    check("valid drained", 32'(vld), 32'h0);
    stall <= 1'b1;
  endtask
  task automatic t_baud(input logic [31:0] mode, input logic [31:0] baud, input int per);
    int n = 0;
    int c = 0;
    int w = 0;
    wr(MODE_CTRL_ADDR, mode);
    wr(BAUD_GEN_ADDR, baud);
    // Bound on all cycles, so a dead baud clock cannot hang the run
    while (n < 10 && w < 3000) begin
      @(posedge clk_in);
      #1;
      w++;
      if (n > 1) c++;
      if (tick === 1'b1) n++;
    end
    if (n < 10) begin
      check("tick wait", 32'(n), 32'd10);
      summarize();
    end
    check("eight periods", 32'(c), 32'(8 * per) + baud[18:16]);
  endtask
  task automatic t_off();
    int n = 0;
    wr(BAUD_GEN_ADDR, 32'h0);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_in);
      #1;
      if (i > 2 && tick !== 1'b0) n++;
    end
    check("ticks off", 32'(n), 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    t_prot();
    t_hold();
    t_baud(32'h0, 32'h2, 32);
    t_baud(32'h4, 32'h3, 24);
    t_baud(32'h0, 32'h7_0001, 16);
    t_baud(32'h1, 32'h5, 5);
    t_baud(32'h2, 32'h3_0004, 4);
    t_baud(32'h6_0003, 32'h2, 12);
    t_off();
    summarize();
  end
endmodule

// ===== testbench/usart_tx_holding_baud_gen_sva.sv
// Purpose: Port assertions for the holding and baud block
// Assumes: Config writes seen on the port mirror the block state
// Notes:   Period checks skip the first tick after any baud or mode register write
`timescale 1ns/1ps
module usart_tx_holding_baud_gen_sva (
  // Block inputs
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic        tx_ready_in,
  // Block outputs
  input wire logic [31:0] rdata_out,
  input wire logic        tx_valid_out,
  input wire logic [8:0]  tx_char_value_out,
  input wire logic        tx_sync_as_command_out,
  input wire logic        tx_holding_ready_out,
  input wire logic        baud_tick_out
);
  import tx_baud_pkg::*;
  logic [18:0] bg;
  logic [26:0] mr;
  logic        wp;
  logic        arm;
  int          g;
  int          per;
  wire wb = wr_in && addr_in == BAUD_GEN_ADDR;
  wire wm = wr_in && addr_in == MODE_CTRL_ADDR;
  wire wh = wr_in && addr_in == TX_HOLDING_ADDR && !tx_valid_out;
  wire tk = baud_tick_out && arm;
  wire ok = g == per || (bg[18:16] != 3'h0 && g == per + 1);
  assign per = mr[1:0] == MODE_ASYNC ? bg[15:0] * (mr[OVER_BIT] ? 8 : 16) :
               mr[1:0] == MODE_ISO ? bg[15:0] * mr[26:16] : bg[15:0];
  // Shadow config; a tick right after a change is not judged
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bg  <= 19'h0;
      mr  <= {RATIO_RESET, 16'h0};
      wp  <= 1'b0;
      arm <= 1'b0;
      g   <= 0;
    end else begin
      if (wb && !wp) bg <= wdata_in[18:0];
      if (wm) mr <= wdata_in[26:0];
      if (wr_in && addr_in == WR_PROT_ADDR) wp <= wdata_in[WRITE_PROTECT_ENABLE_BIT];
      arm <= (arm || baud_tick_out) && !wb && !wm;
      g   <= baud_tick_out ? 1 : g + 1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  property p_async; tk && mr[1:0] == MODE_ASYNC |-> ok; endproperty
  property p_sync; tk && (mr[1:0] == MODE_SYNC || mr[1:0] == MODE_SPI) |-> ok; endproperty
  property p_iso; tk && mr[1:0] == MODE_ISO |-> ok; endproperty
  property p_frac; tk && bg[18:16] == 3'h0 |-> g == per; endproperty
  property p_off; (bg[15:0] == 16'h0) [*3] |-> !baud_tick_out; endproperty
  property p_prot; rd_in && addr_in == BAUD_GEN_ADDR |=> rdata_out == {13'h0, bg}; endproperty
  property p_load; wh |=> tx_valid_out && tx_char_value_out == $past(wdata_in[CHAR_MSB:0]);
  endproperty
  property p_synb; wh |=> tx_sync_as_command_out == $past(wdata_in[SYNC_BIT]); endproperty
  property p_hold; tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable({tx_sync_as_command_out, tx_char_value_out}); endproperty
  a_async: assert property (p_async) else $error("async period wrong");
  a_sync: assert property (p_sync) else $error("sync period wrong");
  a_iso: assert property (p_iso) else $error("iso period wrong");
  a_frac: assert property (p_frac) else $error("period stretched");
  a_off: assert property (p_off) else $error("tick with zero divider");
  a_prot: assert property (p_prot) else $error("baud readback wrong");
  a_load: assert property (p_load) else $error("char not presented");
  a_synb: assert property (p_synb) else $error("sync flag wrong");
  a_hold: assert property (p_hold) else $error("char lost in stall");
  c_tick: cover property (tk);
  c_full: cover property (!tx_holding_ready_out);
  c_stall: cover property (tx_valid_out && !tx_ready_in [*2]);
endmodule
bind usart_tx_holding_baud_gen usart_tx_holding_baud_gen_sva usart_tx_holding_baud_gen_sva_i (
  .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .tx_ready_in(tx_ready_in), .rdata_out(rdata_out),
  .tx_valid_out(tx_valid_out), .tx_char_value_out(tx_char_value_out),
  .tx_sync_as_command_out(tx_sync_as_command_out),
  .tx_holding_ready_out(tx_holding_ready_out), .baud_tick_out(baud_tick_out));
